/* design/snr_pkg.sv */
package snr_pkg;
	// Opcodes seen on the link.
	localparam logic [7:0] OP_ARM_WRITE_CMD = 8'h06;
	localparam logic [7:0] OP_DISARM_WRITE_CMD = 8'h04;
	localparam logic [7:0] OP_STATUS_FETCH_CMD = 8'h05;
	localparam logic [7:0] OP_STATUS_STORE_CMD = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0b;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_IDENTITY_READ_CMD = 8'h9f;
	// Protection status field positions.
	localparam int PIN_GUARD_ON_BIT = 7;
	localparam int AREA_LOCK_HI_BIT = 3;
	localparam int AREA_LOCK_LO_BIT = 2;
	localparam int WRITE_LATCH_FLAG_BIT = 1;
	localparam logic PIN_GUARD_RST = 1'b0;
	localparam logic [1:0] AREA_LOCK_INIT = 2'b00;
	// Array geometry and locked areas.
	localparam int ADDR_W = 14;
	localparam int MEM_DEPTH = 16384;
	localparam logic [13:0] LOCK_QUARTER_BASE = 14'h3000;
	localparam logic [13:0] LOCK_HALF_BASE = 14'h2000;
	// Identity readout: continuation byte count and byte values (values arbitrary).
	localparam int ID_CONT_N = 6;
	localparam logic [7:0] ID_CONT_BYTE = 8'h5a;
	localparam logic [7:0] ID_MAKER_BYTE = 8'h3c;
	localparam logic [7:0] ID_PROD0_BYTE = 8'h12;
	localparam logic [7:0] ID_PROD1_BYTE = 8'h34;
	// Timing.
	localparam int CLK_PERIOD_NS = 25;
	localparam int WAKE_TIME_NS = 400000;
	localparam int WAKE_CYC = WAKE_TIME_NS / CLK_PERIOD_NS;
	localparam int SCLK_HALF_CYC = 8;
	// Synchroniser reset value for {sclk, cs_n, mosi, hold_n, wp_n}.
	localparam logic [4:0] PIN_SYNC_RST = 5'h0b;
	// Controller registers on the Wishbone side, byte addresses.
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] TXD_OFS = 4'h4;
	localparam logic [3:0] RXD_OFS = 4'h8;
	localparam logic [3:0] STAT_OFS = 4'hc;
	localparam int CTRL_CS_BIT = 0;
	localparam int CTRL_PAUSE_BIT = 1;
	localparam int CTRL_WPLOW_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;

	typedef enum logic [3:0] {
		S_IDLE, S_OPC, S_ADDR, S_DUMMY, S_WDATA, S_RDATA,
		S_SRIN, S_SROUT, S_ID, S_SLPQ, S_DONE
	} snr_state_e;

	// True when the address falls inside the area that the lock code covers.
	function automatic logic snr_locked(input logic [1:0] code, input logic [13:0] a);
		case (code)
			2'b01: snr_locked = (a >= LOCK_QUARTER_BASE);
			2'b10: snr_locked = (a >= LOCK_HALF_BASE);
			2'b11: snr_locked = 1'b1;
			default: snr_locked = 1'b0;
		endcase
	endfunction
endpackage

/* design/snr_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface snr_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic hold_n;
	logic wp_n;
	logic miso_wire;

	// The undriven serial output floats high through a pull-up.
	assign miso_wire = miso_oe ? miso : 1'b1;

	modport dev(input sclk, input cs_n, input mosi, input hold_n, input wp_n,
		output miso, output miso_oe);
	modport host(output sclk, output cs_n, output mosi, output hold_n, output wp_n,
		input miso_wire);
endinterface
`default_nettype wire

/* design/snr_dev.sv */
// Overview of operation
// [RULE1] Status write refused when guard set, pin low.
// [RULE2] Status bits 0,4,5,6 read zero always.
// [RULE3] Latch bit set/cleared only by commands.
// [RULE4] Area lock bits keep value across resets.
// [RULE5] Lock code selects protected upper address range.
// [RULE6] Writes need latch set and unlocked address.
// [RULE7] Guard clear means pin ignored entirely.
// [RULE8] Write: opcode, 14-bit address, sequential data bytes.
// [RULE9] Address increments per byte, wraps at top.
// [RULE10] Byte committed at eighth bit; select rise ends.
// [RULE11] Protect pin sampled only at select fall.
// [RULE12] Read: opcode, address, then MSB-first data out.
// [RULE13] Select rise ends reads, floats output.
// [RULE14] Fast read adds one ignored dummy byte.
// [RULE15] Pause pin freezes operation, clock low only.
// [RULE16] Master moves pause pin only with clock low.
// [RULE17] Sleep entered after sleep opcode, select rise.
// [RULE18] Asleep: inputs ignored; select fall starts wake.
// [RULE19] Output floats and opcodes ignored while waking.
// [RULE20] Master wakes with dummy read, then waits.
// [RULE21] Identity read: six continuation, maker, two product.
// [RULE22] First byte after select fall is the opcode.
// [RULE23] Completed write sequence clears the latch.
// [RULE24] Refused bytes dropped silently, address still advances.
`timescale 1ns/100ps
`default_nettype none
module snr_dev #(
	parameter int WAKE_CYCLES = snr_pkg::WAKE_CYC
) (
	input wire logic sys_clk_in, // System clock, 40 MHz.
	input wire logic rst_b_in, // Asynchronous reset, active low.
	snr_link_if.dev link, // Serial link pins.
	output logic asleep_out, // High while in sleep.
	output logic waking_out, // High during wake-up.
	output logic [7:0] status_out // Protection status as read back.
);
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	logic sck_prev_ff;
	logic csn_prev_ff;
	logic pause_ff;
	logic sck;
	logic csn;
	logic din;
	logic live;
	logic rise;
	logic fall;
	logic cs_fall;
	logic cs_rise;
	logic byte_done;
	logic [7:0] in_byte;
	snr_pkg::snr_state_e st_ff;
	logic [2:0] bit_ff;
	logic [6:0] sh_ff;
	logic addr_hi_ff;
	logic [13:0] addr_ff;
	logic [7:0] op_ff;
	logic wp_lat_ff;
	logic wel_ff;
	logic guard_ff;
	logic [1:0] lock_ff = snr_pkg::AREA_LOCK_INIT;
	logic [7:0] mem [0:snr_pkg::MEM_DEPTH-1];
	logic sleep_ff;
	logic [31:0] wake_cnt_ff;
	logic ignore_ff;
	logic [3:0] id_idx_ff;
	logic [7:0] tx_ff;
	logic miso_ff;
	logic [7:0] out_byte;
	logic [7:0] id_byte;
	logic out_state;
	logic waking;

	// Every pin passes two flops before use.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync1_ff <= snr_pkg::PIN_SYNC_RST;
			sync2_ff <= snr_pkg::PIN_SYNC_RST;
		end else begin
			sync1_ff <= {link.sclk, link.cs_n, link.mosi, link.hold_n, link.wp_n};
			sync2_ff <= sync1_ff;
		end
	end

	assign sck = sync2_ff[4];
	assign csn = sync2_ff[3];
	assign din = sync2_ff[2];

	// Pause state follows the pin only while the clock is low.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pause_ff <= 1'b0;
		end else if (!sck) begin
			pause_ff <= !sync2_ff[1]; // [RULE15]
		end
	end

	assign live = !pause_ff;

	// Edge history freezes during a pause, so toggles in between are not seen.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sck_prev_ff <= 1'b0;
			csn_prev_ff <= 1'b1;
		end else if (live) begin
			sck_prev_ff <= sck; // [RULE15]
			csn_prev_ff <= csn;
		end
	end

	assign cs_fall = live && csn_prev_ff && !csn;
	assign cs_rise = live && !csn_prev_ff && csn;
	assign rise = live && !csn && !ignore_ff && sck && !sck_prev_ff;
	assign fall = live && !csn && !ignore_ff && !sck && sck_prev_ff;
	assign byte_done = rise && (bit_ff == 3'd7);
	assign in_byte = {sh_ff, din};
	assign waking = (wake_cnt_ff != 32'd0);

	// Sleep entry, wake-up timing and frames that fall in either.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sleep_ff <= 1'b0;
			wake_cnt_ff <= 32'd0;
			ignore_ff <= 1'b0;
		end else begin
			if (waking) begin
				wake_cnt_ff <= wake_cnt_ff - 32'd1;
			end
			if (cs_fall) begin
				ignore_ff <= sleep_ff || waking; // [RULE19]
				if (sleep_ff) begin
					sleep_ff <= 1'b0;
					wake_cnt_ff <= 32'(WAKE_CYCLES); // [RULE18]
				end
			end else if (cs_rise && st_ff == snr_pkg::S_SLPQ) begin
				sleep_ff <= 1'b1; // [RULE17]
			end
		end
	end

	// Byte framing and command sequencing.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_ff <= snr_pkg::S_IDLE;
			bit_ff <= 3'd0;
			sh_ff <= 7'h00;
			op_ff <= 8'h00;
			addr_hi_ff <= 1'b1;
			wp_lat_ff <= 1'b1;
		end else if (cs_fall) begin
			st_ff <= (sleep_ff || waking) ? snr_pkg::S_IDLE : snr_pkg::S_OPC; // [RULE22]
			bit_ff <= 3'd0;
			addr_hi_ff <= 1'b1;
			wp_lat_ff <= sync2_ff[0]; // [RULE11]
		end else if (cs_rise) begin
			st_ff <= snr_pkg::S_IDLE; // [RULE13]
		end else if (rise) begin
			sh_ff <= in_byte[6:0];
			bit_ff <= bit_ff + 3'd1;
			if (byte_done) begin
				case (st_ff)
					snr_pkg::S_OPC: begin
						op_ff <= in_byte;
						case (in_byte)
							snr_pkg::OP_READ, snr_pkg::OP_FAST_READ, snr_pkg::OP_WRITE:
								st_ff <= snr_pkg::S_ADDR;
							snr_pkg::OP_STATUS_FETCH_CMD: st_ff <= snr_pkg::S_SROUT;
							snr_pkg::OP_STATUS_STORE_CMD: st_ff <= snr_pkg::S_SRIN;
							snr_pkg::OP_IDENTITY_READ_CMD: st_ff <= snr_pkg::S_ID;
							snr_pkg::OP_SLEEP: st_ff <= snr_pkg::S_SLPQ;
							default: st_ff <= snr_pkg::S_DONE;
						endcase
					end
					snr_pkg::S_ADDR: begin
						addr_hi_ff <= 1'b0;
						if (!addr_hi_ff) begin
							case (op_ff)
								snr_pkg::OP_WRITE: st_ff <= snr_pkg::S_WDATA; // [RULE8]
								snr_pkg::OP_FAST_READ: st_ff <= snr_pkg::S_DUMMY; // [RULE14]
								default: st_ff <= snr_pkg::S_RDATA; // [RULE12]
							endcase
						end
					end
					snr_pkg::S_DUMMY: st_ff <= snr_pkg::S_RDATA; // [RULE14]
					snr_pkg::S_SRIN: st_ff <= snr_pkg::S_DONE;
					default: st_ff <= st_ff;
				endcase
			end
		end
	end

	// Address load from the two address bytes and per-byte advance with wrap.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			addr_ff <= 14'h0000;
		end else if (byte_done) begin
			if (st_ff == snr_pkg::S_ADDR && addr_hi_ff) begin
				addr_ff <= {in_byte[5:0], addr_ff[7:0]};
			end else if (st_ff == snr_pkg::S_ADDR) begin
				addr_ff <= {addr_ff[13:8], in_byte};
			end else if (st_ff == snr_pkg::S_WDATA || st_ff == snr_pkg::S_RDATA) begin
				addr_ff <= addr_ff + 14'h0001; // [RULE9] [RULE24]
			end
		end
	end

	// Array commit at the eighth bit; refused bytes vanish silently.
	always_ff @(posedge sys_clk_in) begin
		if (byte_done && st_ff == snr_pkg::S_WDATA && wel_ff
			&& !snr_pkg::snr_locked(lock_ff, addr_ff)) begin
			mem[addr_ff] <= in_byte; // [RULE5] [RULE6] [RULE7] [RULE10] [RULE24]
		end
	end

	// Write latch: commands set and clear it, finished writes clear it.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wel_ff <= 1'b0;
		end else if (byte_done && st_ff == snr_pkg::S_OPC
			&& in_byte == snr_pkg::OP_ARM_WRITE_CMD) begin
			wel_ff <= 1'b1; // [RULE3]
		end else if (byte_done && st_ff == snr_pkg::S_OPC
			&& in_byte == snr_pkg::OP_DISARM_WRITE_CMD) begin
			wel_ff <= 1'b0; // [RULE3]
		end else if (byte_done && st_ff == snr_pkg::S_SRIN) begin
			wel_ff <= 1'b0; // [RULE23]
		end else if (cs_rise && st_ff == snr_pkg::S_WDATA) begin
			wel_ff <= 1'b0; // [RULE10] [RULE23]
		end
	end

	// Guard bit; reset clears it, unlike the area lock.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			guard_ff <= snr_pkg::PIN_GUARD_RST;
		end else if (byte_done && st_ff == snr_pkg::S_SRIN && wel_ff
			&& !(guard_ff && !wp_lat_ff)) begin
			guard_ff <= in_byte[snr_pkg::PIN_GUARD_ON_BIT]; // [RULE1] [RULE7]
		end
	end

	// Area lock has no reset so it survives like stored data.
	always_ff @(posedge sys_clk_in) begin
		if (byte_done && st_ff == snr_pkg::S_SRIN && wel_ff
			&& !(guard_ff && !wp_lat_ff)) begin
			lock_ff <= in_byte[snr_pkg::AREA_LOCK_HI_BIT:snr_pkg::AREA_LOCK_LO_BIT]; // [RULE1] [RULE4]
		end
	end

	// Fixed bits are constants and ignore anything written.
	assign status_out = {guard_ff, 3'b000, lock_ff, wel_ff, 1'b0}; // [RULE2] [RULE3]

	// Identity byte by position; past the last byte zeros follow.
	always_comb begin
		if (id_idx_ff < 4'(snr_pkg::ID_CONT_N)) begin
			id_byte = snr_pkg::ID_CONT_BYTE; // [RULE21]
		end else if (id_idx_ff == 4'(snr_pkg::ID_CONT_N)) begin
			id_byte = snr_pkg::ID_MAKER_BYTE;
		end else if (id_idx_ff == 4'(snr_pkg::ID_CONT_N + 1)) begin
			id_byte = snr_pkg::ID_PROD0_BYTE;
		end else if (id_idx_ff == 4'(snr_pkg::ID_CONT_N + 2)) begin
			id_byte = snr_pkg::ID_PROD1_BYTE;
		end else begin
			id_byte = 8'h00;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			id_idx_ff <= 4'h0;
		end else if (cs_fall) begin
			id_idx_ff <= 4'h0;
		end else if (byte_done && st_ff == snr_pkg::S_ID && id_idx_ff != 4'hf) begin
			id_idx_ff <= id_idx_ff + 4'h1;
		end
	end

	always_comb begin
		case (st_ff)
			snr_pkg::S_RDATA: out_byte = mem[addr_ff];
			snr_pkg::S_SROUT: out_byte = status_out;
			snr_pkg::S_ID: out_byte = id_byte;
			default: out_byte = 8'h00;
		endcase
	end

	assign out_state = (st_ff == snr_pkg::S_RDATA) || (st_ff == snr_pkg::S_SROUT)
		|| (st_ff == snr_pkg::S_ID);

	// Output bits change on falling clock edges, a new byte at bit zero.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_ff <= 8'h00;
			miso_ff <= 1'b0;
		end else if (fall && out_state) begin
			if (bit_ff == 3'd0) begin
				miso_ff <= out_byte[7]; // [RULE12]
				tx_ff <= {out_byte[6:0], 1'b0};
			end else begin
				miso_ff <= tx_ff[7];
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
		end
	end

	// Output floats outside data phases, in a pause, asleep or waking.
	assign link.miso = miso_ff;
	assign link.miso_oe = out_state && !pause_ff && !sleep_ff && !waking; // [RULE13] [RULE18] [RULE19]
	assign asleep_out = sleep_ff;
	assign waking_out = waking;
endmodule
`default_nettype wire

/* design/snr_host.sv */
`timescale 1ns/100ps
`default_nettype none
module snr_host #(
	parameter int SCLK_HALF = snr_pkg::SCLK_HALF_CYC
) (
	input wire logic sys_clk_in, // System clock, 40 MHz.
	input wire logic rst_b_in, // Asynchronous reset, active low.
	input wire logic wb_cyc_i, // Wishbone cycle.
	input wire logic wb_stb_i, // Wishbone strobe.
	input wire logic wb_we_i, // Wishbone write enable.
	input wire logic [3:0] wb_adr_i, // Byte address.
	input wire logic [3:0] wb_sel_i, // Byte lane selects.
	input wire logic [31:0] wb_dat_i, // Write data.
	output logic [31:0] wb_dat_o, // Read data.
	output logic wb_ack_o, // Acknowledge.
	snr_link_if.host link // Serial link pins.
);
	logic [2:0] ctrl_ff;
	logic pause_pin_ff;
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic busy_ff;
	logic sclk_ff;
	logic [4:0] phase_ff;
	logic [15:0] div_ff;
	logic [7:0] txsh_ff;
	logic [7:0] rx_ff;
	logic miso_s1_ff;
	logic miso_s2_ff;
	logic req;
	logic tick;

	assign req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign tick = busy_ff && !pause_pin_ff && (div_ff == 16'(SCLK_HALF - 1));

	// Returned data passes two flops first.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			miso_s1_ff <= 1'b1;
			miso_s2_ff <= 1'b1;
		end else begin
			miso_s1_ff <= link.miso_wire;
			miso_s2_ff <= miso_s1_ff;
		end
	end

	// Bus slave: one wait state, ack for one cycle, unmapped reads give zero.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0;
			ctrl_ff <= snr_pkg::CTRL_RST;
		end else begin
			ack_ff <= req;
			if (req && !wb_we_i) begin
				case (wb_adr_i)
					snr_pkg::CTRL_OFS: rdat_ff <= {29'h0, ctrl_ff};
					snr_pkg::RXD_OFS: rdat_ff <= {24'h0, rx_ff};
					snr_pkg::STAT_OFS: rdat_ff <= {31'h0, busy_ff};
					default: rdat_ff <= 32'h0;
				endcase
			end
			if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == snr_pkg::CTRL_OFS) begin
				ctrl_ff <= wb_dat_i[2:0];
			end
		end
	end

	// Pause pin only moves while the serial clock is low and not about to rise.
	// Moving it on a rising tick would put both pin changes in one sampling window.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pause_pin_ff <= 1'b0;
		end else if (!sclk_ff && !tick) begin
			pause_pin_ff <= ctrl_ff[snr_pkg::CTRL_PAUSE_BIT]; // [RULE16]
		end
	end

	// Byte engine, mode 0: 16 half periods, sample on rise, shift on fall.
	// A transmit write while busy is dropped; poll the busy bit first.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			busy_ff <= 1'b0;
			sclk_ff <= 1'b0;
			phase_ff <= 5'd0;
			div_ff <= 16'd0;
			txsh_ff <= 8'h00;
			rx_ff <= 8'h00;
		end else if (!busy_ff) begin
			if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == snr_pkg::TXD_OFS) begin
				busy_ff <= 1'b1; // [RULE8] [RULE12] [RULE22]
				txsh_ff <= wb_dat_i[7:0];
				phase_ff <= 5'd0;
				div_ff <= 16'd0;
			end
		end else if (!pause_pin_ff) begin
			div_ff <= tick ? 16'd0 : div_ff + 16'd1;
			if (tick) begin
				sclk_ff <= !sclk_ff;
				phase_ff <= phase_ff + 5'd1;
				if (!sclk_ff) begin
					rx_ff <= {rx_ff[6:0], miso_s2_ff};
				end else begin
					txsh_ff <= {txsh_ff[6:0], 1'b0};
				end
				if (phase_ff == 5'd15) begin
					busy_ff <= 1'b0;
				end
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign link.sclk = sclk_ff;
	assign link.mosi = txsh_ff[7];
	assign link.cs_n = !ctrl_ff[snr_pkg::CTRL_CS_BIT];
	assign link.hold_n = !pause_pin_ff;
	assign link.wp_n = !ctrl_ff[snr_pkg::CTRL_WPLOW_BIT];
endmodule
`default_nettype wire

/* tb/snr_link_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module snr_link_monitor #(
	parameter int WAKE_CYCLES = 50
) (
	input wire logic sys_clk_in, // System clock.
	input wire logic rst_b_in, // Reset, active low.
	input wire logic sclk, // Serial clock.
	input wire logic cs_n, // Select, active low.
	input wire logic miso, // Device data bit.
	input wire logic miso_oe, // Device drives data.
	input wire logic hold_n, // Pause pin.
	input wire logic asleep_out, // Sleep flag.
	input wire logic waking_out, // Wake-up flag.
	input wire logic [7:0] status_out // Protection status.
);
	// Slack allows for the device's two-flop pin synchronisers.
	localparam int WK_LO = WAKE_CYCLES - 3;
	localparam int WK_HI = WAKE_CYCLES + 3;
	logic [15:0] wk_cnt_ff;

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	// Counts the cycles of the current wake-up.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wk_cnt_ff <= 16'h0;
		end else begin
			wk_cnt_ff <= waking_out ? wk_cnt_ff + 16'h1 : 16'h0;
		end
	end

	sequence cs_idle;
		cs_n [*6];
	endsequence
	sequence sleep_idle;
		(asleep_out && cs_n) [*4];
	endsequence

	idle_float_a: assert property (cs_idle |-> !miso_oe) else $error("output driven while deselected");
	sleep_float_a: assert property (asleep_out |-> !miso_oe) else $error("output driven in sleep");
	wake_float_a: assert property (waking_out |-> !miso_oe) else $error("output driven while waking");
	wake_start_a: assert property (asleep_out && $fell(cs_n) |-> ##[1:6] waking_out)
		else $error("select fall did not start wake-up");
	wake_bound_a: assert property (waking_out |-> wk_cnt_ff <= WK_HI) else $error("wake-up too long");
	wake_len_a: assert property ($fell(waking_out) |-> wk_cnt_ff >= WK_LO) else $error("wake-up too short");
	sleep_hold_a: assert property (sleep_idle |=> asleep_out) else $error("sleep left without select fall");
	sleep_entry_a: assert property ($rose(asleep_out) |-> cs_n) else $error("sleep entered with select low");
	zero_bits_a: assert property (status_out[6:4] == 3'h0 && !status_out[0]) else $error("fixed bits not zero");
	pause_edge_a: assert property ($changed(hold_n) |-> !sclk) else $error("pause moved with clock high");
	bit_hold_a: assert property ($rose(sclk) && miso_oe |-> ##1 $stable(miso) [*4])
		else $error("data bit changed while clock high");
	cover property ($rose(waking_out));
endmodule
`default_nettype wire

/* tb/spi_nonvolatile_ram_slave_test.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_nonvolatile_ram_slave_test;
	localparam int WAKE = 50;
	localparam int LIMIT = 90000;
	logic sys_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic asleep;
	logic waking;
	logic [7:0] status;
	logic [7:0] exp_q[$];
	logic rd_chk = 1'b0;
	logic wpb = 1'b0;
	logic [7:0] lf = 8'h42;
	logic [1:0] lock_m = 2'h0;
	logic [7:0] mem_m [16384];
	int failures = 0;
	int n_compared = 0;
	int cyc_n = 0;

	snr_link_if lnk();
	snr_host snr_host_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .link(lnk));
	snr_dev #(.WAKE_CYCLES(WAKE)) snr_dev_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
		.link(lnk), .asleep_out(asleep), .waking_out(waking), .status_out(status));
	snr_link_monitor #(.WAKE_CYCLES(WAKE)) snr_link_monitor_i (.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .miso(lnk.miso),
		.miso_oe(lnk.miso_oe), .hold_n(lnk.hold_n), .asleep_out(asleep),
		.waking_out(waking), .status_out(status));

	always #12.5 sys_clk_in = ~sys_clk_in;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task end_sim();
		$display("compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// A hung handshake counts against the run instead of stalling it.
	always @(posedge sys_clk_in) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == LIMIT) begin
			failures++;
			end_sim();
		end
	end

	// Each received byte is judged against the oldest note.
	always @(negedge sys_clk_in) begin
		if (rd_chk && ack === 1'b1) begin
			check({24'h0, rdat[7:0]}, {24'h0, exp_q.pop_front()});
		end
	end

	function automatic logic [7:0] lfsr_next();
		lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		return lf;
	endfunction

	function automatic logic lk(input logic [1:0] c, input logic [13:0] a);
		return (c == 2'h3) || (c == 2'h2 && a >= 14'h2000) || (c == 2'h1 && a >= 14'h3000);
	endfunction

	// Classic cycle: the request stands until the rising edge that samples ack high.
	// Read data is taken at that same edge, and only then is the request released.
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'h1;
		@(posedge sys_clk_in);
		while (ack !== 1'b1) @(posedge sys_clk_in);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task ctl(input logic c, input logic p);
		logic [31:0] q;
		wb(1'b1, snr_pkg::CTRL_OFS, {29'h0, wpb, p, c}, q);
	endtask

	task spi(input logic [7:0] b, input logic chk, input logic [7:0] e);
		logic [31:0] q;
		wb(1'b1, snr_pkg::TXD_OFS, {24'h0, b}, q);
		q = 32'h1;
		while (q[0] !== 1'b0) wb(1'b0, snr_pkg::STAT_OFS, 32'h0, q);
		if (chk) begin
			exp_q.push_back(e);
			rd_chk = 1'b1;
			wb(1'b0, snr_pkg::RXD_OFS, 32'h0, q);
			rd_chk = 1'b0;
		end
	endtask

	task cmd(input logic [7:0] op);
		ctl(1'b1, 1'b0);
		spi(op, 1'b0, 8'h0);
		ctl(1'b0, 1'b0);
	endtask

	task store(input logic arm, input logic [7:0] v);
		if (arm) cmd(snr_pkg::OP_ARM_WRITE_CMD);
		ctl(1'b1, 1'b0);
		spi(snr_pkg::OP_STATUS_STORE_CMD, 1'b0, 8'h0);
		spi(v, 1'b0, 8'h0);
		ctl(1'b0, 1'b0);
	endtask

	task st_chk(input logic [7:0] e);
		ctl(1'b1, 1'b0);
		spi(snr_pkg::OP_STATUS_FETCH_CMD, 1'b0, 8'h0);
		spi(lfsr_next(), 1'b1, e);
		ctl(1'b0, 1'b0);
	endtask

	// The model only takes bytes that the latch and the lock code let through.
	task wr(input logic arm, input logic [13:0] a, input int n);
		logic [7:0] v;
		if (arm) cmd(snr_pkg::OP_ARM_WRITE_CMD);
		ctl(1'b1, 1'b0);
		spi(snr_pkg::OP_WRITE, 1'b0, 8'h0);
		spi({2'b00, a[13:8]}, 1'b0, 8'h0);
		spi(a[7:0], 1'b0, 8'h0);
		for (int i = 0; i < n; i++) begin
			v = lfsr_next();
			spi(v, 1'b0, 8'h0);
			if (arm && !lk(lock_m, a)) mem_m[a] = v;
			a = a + 14'h1;
		end
		ctl(1'b0, 1'b0);
	endtask

	task rd(input logic [7:0] op, input logic [13:0] a, input int n, input logic pz);
		ctl(1'b1, 1'b0);
		spi(op, 1'b0, 8'h0);
		spi({2'b00, a[13:8]}, 1'b0, 8'h0);
		spi(a[7:0], 1'b0, 8'h0);
		if (op == snr_pkg::OP_FAST_READ) spi(lfsr_next(), 1'b0, 8'h0);
		if (pz) begin
			ctl(1'b1, 1'b1);
			repeat (40) @(posedge sys_clk_in);
			ctl(1'b1, 1'b0);
		end
		for (int i = 0; i < n; i++) begin
			spi(lfsr_next(), 1'b1, mem_m[a]);
			a = a + 14'h1;
		end
		ctl(1'b0, 1'b0);
	endtask

	// Main sequence; a second reset near the end shows the lock bits surviving.
	initial begin
		repeat (10) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		st_chk(8'h00);
		cmd(snr_pkg::OP_ARM_WRITE_CMD);
		st_chk(8'h02);
		cmd(snr_pkg::OP_DISARM_WRITE_CMD);
		st_chk(8'h00);
		store(1'b1, 8'h7f);
		st_chk(8'h0c);
		store(1'b1, 8'h00);
		wr(1'b1, 14'h3fff, 3);
		st_chk(8'h00);
		rd(snr_pkg::OP_READ, 14'h3fff, 3, 1'b0);
		rd(snr_pkg::OP_FAST_READ, 14'h3fff, 3, 1'b1);
		wr(1'b0, 14'h0000, 1);
		rd(snr_pkg::OP_READ, 14'h0000, 1, 1'b0);
		for (int c = 0; c < 4; c++) begin
			lock_m = c[1:0];
			store(1'b1, {4'h0, c[1:0], 2'b00});
			st_chk({4'h0, c[1:0], 2'b00});
			wr(1'b1, 14'h1fff, 2);
			wr(1'b1, 14'h2fff, 2);
			rd(snr_pkg::OP_READ, 14'h1fff, 2, 1'b0);
			rd(snr_pkg::OP_READ, 14'h2fff, 2, 1'b0);
		end
		store(1'b1, 8'h84);
		lock_m = 2'h1;
		st_chk(8'h84);
		wpb = 1'b1;
		store(1'b1, 8'h00);
		st_chk(8'h84);
		wr(1'b1, 14'h3fff, 2);
		rd(snr_pkg::OP_READ, 14'h3fff, 2, 1'b0);
		wpb = 1'b0;
		store(1'b1, 8'h00);
		st_chk(8'h00);
		wpb = 1'b1;
		store(1'b1, 8'h08);
		lock_m = 2'h2;
		st_chk(8'h08);
		wpb = 1'b0;
		store(1'b0, 8'h00);
		st_chk(8'h08);
		ctl(1'b1, 1'b0);
		spi(snr_pkg::OP_IDENTITY_READ_CMD, 1'b0, 8'h0);
		repeat (snr_pkg::ID_CONT_N) spi(lfsr_next(), 1'b1, snr_pkg::ID_CONT_BYTE);
		spi(lfsr_next(), 1'b1, snr_pkg::ID_MAKER_BYTE);
		spi(lfsr_next(), 1'b1, snr_pkg::ID_PROD0_BYTE);
		spi(lfsr_next(), 1'b1, snr_pkg::ID_PROD1_BYTE);
		ctl(1'b0, 1'b0);
		cmd(snr_pkg::OP_SLEEP);
		repeat (6) @(negedge sys_clk_in);
		check({31'h0, asleep}, 32'h1);
		cmd(snr_pkg::OP_READ);
		repeat (WAKE + 10) @(negedge sys_clk_in);
		check({31'h0, waking}, 32'h0);
		rd(snr_pkg::OP_READ, 14'h3fff, 2, 1'b0);
		rst_b_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		st_chk(8'h08);
		end_sim();
	end
endmodule
`default_nettype wire
